/* gcl_loader.sv */
// Notes on behaviour
// - Current scaled to mA by gain word 0x68
// - Charge accumulation scaled by gain word 0x6a
// - Calibration command stores opposite-sign offset correction
// - Offset result written to low 21 bits
// - Low 20 bits magnitude, bit 20 sign
// - Temperature corrected by tenths-degree offset byte
// - Info, date, serial words returned unchanged
// - Manufacturer name length 0x20, chars 0x21-0x2a
// - Device name length 0x30, chars to 0x37
// - Chemistry length 0x40, chars 0x41-0x44
// - Manufacturer data count taken from 0x50
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module gcl_loader (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [15:0] current_ma,
  output logic [31:0] charge_accum,
  output logic [15:0] temp_corrected,
  output logic [20:0] offset_inject,
  output logic cal_busy,
  output logic image_ok
);

  localparam int AW = gcl_pkg::IMG_AW;

  logic addr_phase;
  logic dp_write;
  logic [11:0] dp_addr;
  logic rd_pend;
  logic rd_zero;
  logic bus_img_we;
  logic cal_we;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [15:0] raw_current_reg;
  logic [15:0] raw_charge_reg;
  logic [15:0] raw_temp_reg;
  logic [20:0] meas_offset_reg;
  logic [2:0] func_sel_reg;
  logic [7:0] func_idx_reg;
  logic charge_strobe;
  logic current_strobe;
  logic [15:0] cur_scaled;
  logic [15:0] chg_scaled;
  logic chg_valid;
  logic [15:0] cur_gain_reg;
  logic [15:0] chg_gain_reg;
  logic [23:0] offset_field_reg;
  logic [7:0] temp_offset_reg;
  logic [15:0] check1_reg;
  logic [15:0] check2_reg;
  logic [15:0] spec_info_reg;
  logic [15:0] mfg_date_reg;
  logic [15:0] serial_reg;
  logic [7:0] mfr_len_reg;
  logic [7:0] dev_len_reg;
  logic [7:0] chem_len_reg;
  logic [7:0] mdata_len_reg;
  logic [7:0] func_len;
  logic [23:0] cal_field;
  logic [19:0] meas_mag;
  gcl_pkg::gcl_cal_state_t cal_state;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Length location of a string function
  function automatic logic [6:0] len_loc(input logic [2:0] fn);
    unique case (fn)
      gcl_pkg::FN_MFR_NAME: len_loc = gcl_pkg::LOC_MFR_NAME;
      gcl_pkg::FN_DEV_NAME: len_loc = gcl_pkg::LOC_DEV_NAME;
      default: len_loc = gcl_pkg::LOC_CHEM;
    endcase
  endfunction : len_loc

  // Smaller of stored length and allotted room
  function automatic logic [7:0] clamp_len(input logic [7:0] len, input logic [7:0] room);
    clamp_len = (len > room) ? room : len;
  endfunction : clamp_len

  function automatic logic is_string(input logic [2:0] fn);
    is_string = (fn == gcl_pkg::FN_MFR_NAME) || (fn == gcl_pkg::FN_DEV_NAME)
      || (fn == gcl_pkg::FN_CHEM);
  endfunction : is_string

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign addr_phase = hsel && htrans[1] && hready;
  assign bus_img_we = dp_write && dp_addr[gcl_pkg::WINDOW_BIT];

  // Bus writes win the write port; calibration waits a cycle
  assign cal_we = (cal_state != gcl_pkg::CAL_IDLE) && !bus_img_we;
  assign mem_we = bus_img_we || cal_we;

  always_comb
  begin
    mem_waddr = dp_addr[AW+1:2];
    mem_wdata = hwdata[7:0];
    if (!bus_img_we)
    begin
      unique case (cal_state)
        gcl_pkg::CAL_BYTE0:
        begin
          mem_waddr = gcl_pkg::LOC_CHG_OFFSET;
          mem_wdata = cal_field[7:0];
        end
        gcl_pkg::CAL_BYTE1:
        begin
          mem_waddr = gcl_pkg::LOC_CHG_OFFSET + 7'h01;
          mem_wdata = cal_field[15:8];
        end
        gcl_pkg::CAL_BYTE2:
        begin
          mem_waddr = gcl_pkg::LOC_CHG_OFFSET + 7'h02;
          mem_wdata = cal_field[23:16];
        end
        gcl_pkg::CAL_IDLE:
        begin
          mem_waddr = dp_addr[AW+1:2];
        end
      endcase
    end
  end

  // Stored string length clamped to the characters allotted; manufacturer data count passed as stored
  always_comb
  begin
    unique case (func_sel_reg)
      gcl_pkg::FN_MFR_NAME: func_len = clamp_len(mfr_len_reg, gcl_pkg::MFR_NAME_MAX);
      gcl_pkg::FN_DEV_NAME: func_len = clamp_len(dev_len_reg, gcl_pkg::DEV_NAME_MAX);
      gcl_pkg::FN_CHEM: func_len = clamp_len(chem_len_reg, gcl_pkg::CHEM_MAX);
      gcl_pkg::FN_MFR_DATA: func_len = mdata_len_reg;
      default: func_len = 8'h00;
    endcase
  end

  // Window reads the image directly; strings read past the length byte
  assign mem_raddr = haddr[gcl_pkg::WINDOW_BIT] ? haddr[AW+1:2]
    : len_loc(func_sel_reg) + 7'h01 + func_idx_reg[AW-1:0];

  gcl_image_mem #(.AW(AW), .DW(gcl_pkg::IMG_DW)) u_mem (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data_reg(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: registers answer at once, image bytes and string function data one wait state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dp_write <= 1'b0;
      dp_addr <= '0;
      rd_pend <= 1'b0;
      rd_zero <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
    end
    else
    begin
      hresp <= 1'b0;
      dp_write <= addr_phase && hwrite && (hsize == gcl_pkg::HSIZE_WORD);
      if (addr_phase)
      begin
        dp_addr <= haddr[11:0];
      end
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= rd_zero ? 32'h0000_0000 : {24'h00_0000, mem_rdata};
      end
      else if (addr_phase && !hwrite)
      begin
        hrdata <= 32'h0000_0000;
        if (haddr[gcl_pkg::WINDOW_BIT])
        begin
          rd_pend <= 1'b1;
          rd_zero <= 1'b0;
          hreadyout <= 1'b0;
        end
        else
        begin
          unique case (haddr[11:0])
            gcl_pkg::OFS_MFG_ACCESS: hrdata <= {30'h0, image_ok, cal_busy};
            gcl_pkg::OFS_MEAS_OFFSET: hrdata <= {11'h000, meas_offset_reg};
            gcl_pkg::OFS_CURRENT: hrdata <= {16'h0000, current_ma};
            gcl_pkg::OFS_CHARGE: hrdata <= charge_accum;
            gcl_pkg::OFS_TEMP: hrdata <= {16'h0000, temp_corrected};
            gcl_pkg::OFS_FUNC_SEL: hrdata <= {16'h0000, func_idx_reg, 5'h00, func_sel_reg};
            gcl_pkg::OFS_FUNC_LEN: hrdata <= {24'h00_0000, func_len};
            gcl_pkg::OFS_FUNC_DATA:
            begin
              unique case (func_sel_reg)
                gcl_pkg::FN_SPEC_INFO: hrdata <= {16'h0000, spec_info_reg};
                gcl_pkg::FN_MFG_DATE: hrdata <= {16'h0000, mfg_date_reg};
                gcl_pkg::FN_SERIAL: hrdata <= {16'h0000, serial_reg};
                default:
                begin
                  if (is_string(func_sel_reg))
                  begin
                    rd_pend <= 1'b1;
                    rd_zero <= (func_idx_reg >= func_len);
                    hreadyout <= 1'b0;
                  end
                end
              endcase
            end
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      raw_current_reg <= '0;
      raw_charge_reg <= '0;
      raw_temp_reg <= '0;
      meas_offset_reg <= '0;
      func_sel_reg <= '0;
      func_idx_reg <= '0;
      current_strobe <= 1'b0;
      charge_strobe <= 1'b0;
    end
    else
    begin
      current_strobe <= 1'b0;
      charge_strobe <= 1'b0;
      if (dp_write && !dp_addr[gcl_pkg::WINDOW_BIT])
      begin
        unique case (dp_addr)
          gcl_pkg::OFS_MEAS_OFFSET: meas_offset_reg <= hwdata[20:0];
          gcl_pkg::OFS_CURRENT:
          begin
            raw_current_reg <= hwdata[15:0];
            current_strobe <= 1'b1;
          end
          gcl_pkg::OFS_CHARGE:
          begin
            raw_charge_reg <= hwdata[15:0];
            charge_strobe <= 1'b1;
          end
          gcl_pkg::OFS_TEMP: raw_temp_reg <= hwdata[15:0];
          gcl_pkg::OFS_FUNC_SEL:
          begin
            func_sel_reg <= hwdata[2:0];
            func_idx_reg <= hwdata[15:8];
          end
          default: func_idx_reg <= func_idx_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shadow copies of image fields, tracking every byte written
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_gain_reg <= '0;
      chg_gain_reg <= '0;
      offset_field_reg <= '0;
      temp_offset_reg <= '0;
      check1_reg <= '0;
      check2_reg <= '0;
      spec_info_reg <= '0;
      mfg_date_reg <= '0;
      serial_reg <= '0;
      mfr_len_reg <= '0;
      dev_len_reg <= '0;
      chem_len_reg <= '0;
      mdata_len_reg <= '0;
    end
    else if (mem_we)
    begin
      unique case (mem_waddr)
        gcl_pkg::LOC_CHECK1: check1_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_CHECK1 + 7'h01: check1_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_CHECK2: check2_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_CHECK2 + 7'h01: check2_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_SPEC_INFO: spec_info_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_SPEC_INFO + 7'h01: spec_info_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_MFG_DATE: mfg_date_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_MFG_DATE + 7'h01: mfg_date_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_SERIAL: serial_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_SERIAL + 7'h01: serial_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_MFR_NAME: mfr_len_reg <= mem_wdata;
        gcl_pkg::LOC_DEV_NAME: dev_len_reg <= mem_wdata;
        gcl_pkg::LOC_CHEM: chem_len_reg <= mem_wdata;
        gcl_pkg::LOC_MFR_DATA: mdata_len_reg <= mem_wdata;
        gcl_pkg::LOC_CHG_OFFSET: offset_field_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_CHG_OFFSET + 7'h01: offset_field_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_CHG_OFFSET + 7'h02: offset_field_reg[23:16] <= mem_wdata;
        gcl_pkg::LOC_TEMP_OFFSET: temp_offset_reg <= mem_wdata;
        gcl_pkg::LOC_CUR_GAIN: cur_gain_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_CUR_GAIN + 7'h01: cur_gain_reg[15:8] <= mem_wdata;
        gcl_pkg::LOC_CHG_GAIN: chg_gain_reg[7:0] <= mem_wdata;
        gcl_pkg::LOC_CHG_GAIN + 7'h01: chg_gain_reg[15:8] <= mem_wdata;
        default: mdata_len_reg <= mdata_len_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Offset calibration: store the negated measurement as sign-magnitude

  assign meas_mag = meas_offset_reg[20] ? 20'(-meas_offset_reg) : meas_offset_reg[19:0];
  // Correction is opposite in sign, so a positive reading stores sign one
  assign cal_field = {3'h0, ~meas_offset_reg[20] && (meas_mag != 20'h0_0000), meas_mag};

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cal_state <= gcl_pkg::CAL_IDLE;
    end
    else
    begin
      unique case (cal_state)
        gcl_pkg::CAL_IDLE:
        begin
          // A repeated command while busy is ignored
          if (dp_write && (dp_addr == gcl_pkg::OFS_MFG_ACCESS)
              && (hwdata[15:0] == gcl_pkg::CMD_CAL_START))
          begin
            cal_state <= gcl_pkg::CAL_BYTE0;
          end
        end
        gcl_pkg::CAL_BYTE0: if (cal_we) cal_state <= gcl_pkg::CAL_BYTE1;
        gcl_pkg::CAL_BYTE1: if (cal_we) cal_state <= gcl_pkg::CAL_BYTE2;
        gcl_pkg::CAL_BYTE2: if (cal_we) cal_state <= gcl_pkg::CAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Measurement scaling

  gcl_gain_scaler #(.W(16)) u_cur_scale (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(current_strobe),
    .raw(raw_current_reg),
    .gain(cur_gain_reg),
    .scaled_reg(cur_scaled),
    .out_valid_reg()
  );

  gcl_gain_scaler #(.W(16)) u_chg_scale (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(charge_strobe),
    .raw(raw_charge_reg),
    .gain(chg_gain_reg),
    .scaled_reg(chg_scaled),
    .out_valid_reg(chg_valid)
  );

  // Outputs, all registered
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      current_ma <= '0;
      charge_accum <= '0;
      temp_corrected <= '0;
      offset_inject <= '0;
      cal_busy <= 1'b0;
      image_ok <= 1'b0;
    end
    else
    begin
      current_ma <= cur_scaled;
      if (chg_valid)
      begin
        charge_accum <= charge_accum + {{16{chg_scaled[15]}}, chg_scaled};
      end
      // Offset byte is already in tenths, same unit as the reading
      temp_corrected <= raw_temp_reg + {{8{temp_offset_reg[7]}}, temp_offset_reg};
      // Injected signal follows whatever field the image holds
      offset_inject <= offset_field_reg[gcl_pkg::OFS_SIGN_BIT]
        ? 21'(-{1'b0, offset_field_reg[gcl_pkg::OFS_MAG_W-1:0]})
        : {1'b0, offset_field_reg[gcl_pkg::OFS_MAG_W-1:0]};
      cal_busy <= (cal_state != gcl_pkg::CAL_IDLE);
      image_ok <= (check1_reg == gcl_pkg::CHECK1_VALUE)
        && (check2_reg == gcl_pkg::CHECK2_VALUE);
    end
  end

endmodule : gcl_loader
`default_nettype wire

/* gcl_pkg.sv */
`default_nettype none
package gcl_pkg;

  // Image geometry
  localparam int IMG_AW = 7;
  localparam int IMG_DW = 8;

  // Bus register byte offsets, compared against haddr[11:0]
  localparam logic [11:0] OFS_MFG_ACCESS = 12'h000;
  localparam logic [11:0] OFS_MEAS_OFFSET = 12'h004;
  localparam logic [11:0] OFS_CURRENT = 12'h008;
  localparam logic [11:0] OFS_CHARGE = 12'h00C;
  localparam logic [11:0] OFS_TEMP = 12'h010;
  localparam logic [11:0] OFS_FUNC_SEL = 12'h014;
  localparam logic [11:0] OFS_FUNC_DATA = 12'h018;
  localparam logic [11:0] OFS_FUNC_LEN = 12'h01C;
  localparam int WINDOW_BIT = 10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Image locations, low byte of a word at the lower location
  localparam logic [6:0] LOC_CHECK1 = 7'h00;
  localparam logic [6:0] LOC_SPEC_INFO = 7'h14;
  localparam logic [6:0] LOC_MFG_DATE = 7'h16;
  localparam logic [6:0] LOC_SERIAL = 7'h18;
  localparam logic [6:0] LOC_MFR_NAME = 7'h20;
  localparam logic [6:0] LOC_DEV_NAME = 7'h30;
  localparam logic [6:0] LOC_CHEM = 7'h40;
  localparam logic [6:0] LOC_MFR_DATA = 7'h50;
  localparam logic [6:0] LOC_CHG_OFFSET = 7'h5E;
  localparam logic [6:0] LOC_TEMP_OFFSET = 7'h61;
  localparam logic [6:0] LOC_CUR_GAIN = 7'h68;
  localparam logic [6:0] LOC_CHG_GAIN = 7'h6A;
  localparam logic [6:0] LOC_CHECK2 = 7'h7E;

  // Check words the image must carry
  localparam logic [15:0] CHECK1_VALUE = 16'h3C7F;
  localparam logic [15:0] CHECK2_VALUE = 16'hA55A;

  // Characters allotted to each string
  localparam logic [7:0] MFR_NAME_MAX = 8'h0A;
  localparam logic [7:0] DEV_NAME_MAX = 8'h07;
  localparam logic [7:0] CHEM_MAX = 8'h04;

  // Stored offset field layout
  localparam int OFS_MAG_W = 20;
  localparam int OFS_SIGN_BIT = 20;
  localparam int OFS_FIELD_W = 24;

  // Gain words are fixed point with this many fraction bits
  localparam int GAIN_SHIFT = 16;

  // Command code that starts offset calibration, arbitrary value
  localparam logic [15:0] CMD_CAL_START = 16'h0021;

  // Smart battery functions reachable through the function port
  typedef enum logic [2:0] {
    FN_SPEC_INFO, FN_MFG_DATE, FN_SERIAL, FN_MFR_NAME, FN_DEV_NAME, FN_CHEM, FN_MFR_DATA
  } gcl_func_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_BYTE0, CAL_BYTE1, CAL_BYTE2} gcl_cal_state_t;

endpackage : gcl_pkg
`default_nettype wire

/* gcl_image_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module gcl_image_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_reg
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////
  // Write port, no reset so it maps onto plain storage
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle after the address
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= mem[rd_addr];
    end
  end

endmodule : gcl_image_mem
`default_nettype wire

/* gcl_gain_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
module gcl_gain_scaler #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] raw,
  input wire logic [W-1:0] gain,
  output logic [W-1:0] scaled_reg,
  output logic out_valid_reg
);

  logic signed [2*W:0] product;

  // Signed reading times unsigned gain, fraction bits dropped
  assign product = $signed({raw[W-1], raw}) * $signed({1'b0, gain});

  ////////////////////////////////////////////////////////////////////////
  // Overflow wraps; gains near nominal keep results in range
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scaled_reg <= '0;
      out_valid_reg <= 1'b0;
    end
    else
    begin
      out_valid_reg <= in_valid;
      if (in_valid)
      begin
        scaled_reg <= product[gcl_pkg::GAIN_SHIFT+W-1:gcl_pkg::GAIN_SHIFT];
      end
    end
  end

endmodule : gcl_gain_scaler
`default_nettype wire

/* gcl_loader_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module gcl_loader_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cal_busy
);
  logic rd_dp_reg;
  logic cmd_dp_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Data phase trackers, frozen while the slave stalls
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_dp_reg <= 1'b0;
      cmd_dp_reg <= 1'b0;
    end
    else if (hready)
    begin
      rd_dp_reg <= hsel && htrans[1] && !hwrite;
      cmd_dp_reg <= hsel && htrans[1] && hwrite && hsize == gcl_pkg::HSIZE_WORD
        && haddr[11:0] == gcl_pkg::OFS_MFG_ACCESS;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence taken_s;
    hsel && htrans[1] && hready;
  endsequence
  sequence cal_cmd_s;
    cmd_dp_reg && hready && hwdata[15:0] == gcl_pkg::CMD_CAL_START;
  endsequence
  // Bus answer timing; a stall never lasts past one cycle
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("stall longer than one cycle");
  write_nowait_a: assert property (taken_s ##0 hwrite |=> hreadyout)
    else $error("write stalled");
  image_wait_a: assert property (taken_s ##0 (!hwrite && haddr[10]) |=> !hreadyout ##1 hreadyout)
    else $error("image read timing wrong");
  info_nowait_a: assert property (taken_s ##0 (!hwrite && !haddr[10]
    && haddr[11:0] != gcl_pkg::OFS_FUNC_DATA) |=> hreadyout)
    else $error("register read stalled");
  idle_ready_a: assert property (!rd_dp_reg |-> hreadyout)
    else $error("ready low outside a read");
  hold_data_a: assert property (!(rd_dp_reg || (hsel && htrans[1] && hready && !hwrite))
    |=> $stable(hrdata))
    else $error("read data changed without a read");
  // Calibration starts promptly and ends in bounded time
  cal_start_a: assert property (cal_cmd_s |-> ##[0:4] cal_busy)
    else $error("calibration did not start");
  cal_end_a: assert property ($rose(cal_busy) |-> ##[1:20] !cal_busy)
    else $error("calibration did not finish");
endmodule : gcl_loader_sva
bind gcl_loader gcl_loader_sva i_gcl_loader_sva (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cal_busy(cal_busy));
`default_nettype wire

/* gcl_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gcl_eeprom_model (
  output var logic [1023:0] image
);
  int i;
  // Image as burned into the serial memory
  initial
  begin
    for (i = 0; i < 128; i++)
      image[8*i+:8] = 8'(i * 37 + 11);
    image[7:0] = 8'h7F;
    image[15:8] = 8'h3C;
    image[1015:1008] = 8'h5A;
    image[1023:1016] = 8'hA5;
    // Lengths above and below the allotment
    image[8*gcl_pkg::LOC_MFR_NAME+:8] = 8'h0C;
    image[8*gcl_pkg::LOC_DEV_NAME+:8] = 8'h05;
    image[8*gcl_pkg::LOC_CHEM+:8] = 8'h09;
    image[8*gcl_pkg::LOC_MFR_DATA+:8] = 8'h07;
    image[8*gcl_pkg::LOC_TEMP_OFFSET+:8] = 8'hFB; // Minus half a degree
    image[8*gcl_pkg::LOC_CUR_GAIN+:16] = 16'h4000;
    image[8*gcl_pkg::LOC_CHG_GAIN+:16] = 16'h2000;
  end
endmodule : gcl_eeprom_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, cal_busy, image_ok;
  logic [31:0] haddr, hwdata, hrdata, charge_accum, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] current_ma, temp_corrected;
  logic [20:0] offset_inject;
  logic [1023:0] image;
  int img[128];
  int miscompares, total_checks, seed, i, j, k, f, loc, mx, len, v, want, acc;
  assign hready = hreadyout;
  gcl_loader i_gcl_loader (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .current_ma(current_ma),
    .charge_accum(charge_accum), .temp_corrected(temp_corrected),
    .offset_inject(offset_inject), .cal_busy(cal_busy), .image_ok(image_ok));
  gcl_eeprom_model i_gcl_eeprom_model (.image(image));
  ////////////////////////////////////////////////////////////////////////////
  task chk_val(input logic [31:0] got, input logic [31:0] exp_v);
  begin
    total_checks++;
    if (got !== exp_v)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp_v);
    end
  end
  endtask : chk_val
  task chk_bit(input logic got, input logic exp_v);
    chk_val({31'h0, got}, {31'h0, exp_v});
  endtask : chk_bit
  // Bounded wait for ready sampled at a rising edge
  task wait_rdy;
    int n;
  begin
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50)
    begin
      miscompares++;
      $display("unexpected at %0t: ready never came", $time);
    end
  end
  endtask : wait_rdy
  // One single word transfer; the model mirrors image writes
  task xfer(input logic w, input int a, input logic [31:0] d);
  begin
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= gcl_pkg::HSIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'($random(seed));
    wait_rdy;
    r = hrdata;
    if (w && a >= 1024)
      img[(a - 1024) / 4] = int'(d[7:0]);
  end
  endtask : xfer
  task wr(input int a, input int d);
    xfer(1'b1, a, 32'(d));
  endtask : wr
  task rd(input int a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task close_out;
  begin
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Far longer than the whole sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out;
  end
  initial
  begin
    seed = 51;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge core_clk);
    chk_bit(hreadyout, 1'b1);
    chk_bit(image_ok, 1'b0);
    rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 128; i++)
      wr(1024 + 4 * i, int'(image[8*i+:8]));
    // Break the closing check word, then repair it
    for (j = 2; j >= 0; j--)
    begin
      if (j < 2)
        wr(1024 + 4 * 127, j == 1 ? 0 : 'hA5);
      repeat (3) @(posedge core_clk);
      chk_bit(image_ok, j != 1);
    end
    repeat (4)
    begin
      i = $random(seed) & 127;
      rd(1024 + 4 * i);
      chk_val(r, 32'(img[i]));
    end
    $display("test image done");
    for (f = 0; f < 3; f++)
    begin
      loc = 'h14 + 2 * f;
      wr('h14, f);
      rd('h18);
      chk_val(r, 32'(img[loc + 1] * 256 + img[loc]));
    end
    // Walk one past the allotment of each string
    for (f = 3; f < 6; f++)
    begin
      loc = f == 3 ? 'h20 : f == 4 ? 'h30 : 'h40;
      mx = f == 3 ? 10 : f == 4 ? 7 : 4;
      len = img[loc] < mx ? img[loc] : mx;
      wr('h14, f);
      rd('h1C);
      chk_val(r, 32'(len));
      for (k = 0; k <= mx; k++)
      begin
        wr('h14, k * 256 + f);
        rd('h18);
        chk_val(r, 32'(k < len ? img[loc + 1 + k] : 0));
      end
    end
    wr('h14, 6);
    rd('h1C);
    chk_val(r, 32'(img['h50]));
    rd('h18);
    chk_val(r, 32'h0);
    $display("test functions done");
    repeat (4)
    begin
      v = $random(seed) % 32768;
      wr('h08, v);
      repeat (3) @(posedge core_clk);
      rd('h08);
      want = (v * (img['h69] * 256 + img['h68])) >>> 16;
      chk_val({16'h0, r[15:0]}, {16'h0, 16'(want)});
    end
    acc = 0;
    repeat (3)
    begin
      v = $random(seed) % 32768;
      wr('h0C, v);
      acc += (v * (img['h6B] * 256 + img['h6A])) >>> 16;
      repeat (3) @(posedge core_clk);
    end
    rd('h0C);
    chk_val(r, 32'(acc));
    v = $random(seed) % 2000;
    wr('h10, v);
    repeat (2) @(posedge core_clk);
    rd('h10);
    want = v + img['h61] - (img['h61] > 127 ? 256 : 0);
    chk_val({16'h0, r[15:0]}, {16'h0, 16'(want)});
    $display("test scaling done");
    // Positive then negative measured offset
    for (j = 0; j < 2; j++)
    begin
      v = ($random(seed) & 'hFFFFF) | 1;
      if (j == 1)
        v = -v;
      wr('h04, v);
      wr('h00, 'h21);
      k = 0;
      while (cal_busy !== 1'b1 && k < 20)
      begin
        @(posedge core_clk);
        k++;
      end
      while (cal_busy !== 1'b0 && k < 60)
      begin
        @(posedge core_clk);
        k++;
      end
      chk_bit(cal_busy, 1'b0);
      repeat (3) @(posedge core_clk);
      want = j == 0 ? 'h100000 + v : -v;
      for (k = 0; k < 3; k++)
      begin
        rd(1024 + 4 * ('h5E + k));
        chk_val(r, 32'((want >> (8 * k)) & 255));
      end
      chk_val({11'h0, offset_inject}, 32'(-v) & 32'h1FFFFF);
    end
    $display("test calibration done");
    close_out;
  end
endmodule : tb
`default_nettype wire
